/* File: shared/rvm_pkg.sv */
// constants and carriers for the reset and interrupt vector map
package rvm_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IRQ_N  = 25;
  localparam int unsigned IDX_W  = 5;

  typedef logic [ADDR_W-1:0] rvm_addr_t;
  typedef logic [IRQ_N-1:0]  rvm_irq_t;
  typedef logic [IDX_W-1:0]  rvm_idx_t;

  localparam rvm_addr_t APP_RESET_ADDR = 12'h000;
  localparam rvm_addr_t APP_TABLE_BASE = 12'h001;
  localparam logic      FUSE_PROGRAMMED = 1'b0;

  // request bit positions, in vector order
  localparam rvm_idx_t IDX_EXT_IRQ_0           = 5'h00;
  localparam rvm_idx_t IDX_EXT_IRQ_1           = 5'h01;
  localparam rvm_idx_t IDX_PIN_CHANGE_IRQ_0    = 5'h02;
  localparam rvm_idx_t IDX_PIN_CHANGE_IRQ_1    = 5'h03;
  localparam rvm_idx_t IDX_PIN_CHANGE_IRQ_2    = 5'h04;
  localparam rvm_idx_t IDX_WATCHDOG_TIMEOUT    = 5'h05;
  localparam rvm_idx_t IDX_T2_MATCH_A          = 5'h06;
  localparam rvm_idx_t IDX_T2_MATCH_B          = 5'h07;
  localparam rvm_idx_t IDX_T2_OVERFLOW         = 5'h08;
  localparam rvm_idx_t IDX_T1_CAPTURE          = 5'h09;
  localparam rvm_idx_t IDX_T1_MATCH_A          = 5'h0a;
  localparam rvm_idx_t IDX_T1_MATCH_B          = 5'h0b;
  localparam rvm_idx_t IDX_T1_OVERFLOW         = 5'h0c;
  localparam rvm_idx_t IDX_T0_MATCH_A          = 5'h0d;
  localparam rvm_idx_t IDX_T0_MATCH_B          = 5'h0e;
  localparam rvm_idx_t IDX_T0_OVERFLOW         = 5'h0f;
  localparam rvm_idx_t IDX_SERIAL_PERIPH_DONE  = 5'h10;
  localparam rvm_idx_t IDX_UART_RX_DONE        = 5'h11;
  localparam rvm_idx_t IDX_UART_TX_EMPTY       = 5'h12;
  localparam rvm_idx_t IDX_UART_TX_DONE        = 5'h13;
  localparam rvm_idx_t IDX_CONVERSION_DONE     = 5'h14;
  localparam rvm_idx_t IDX_NV_READY            = 5'h15;
  localparam rvm_idx_t IDX_COMPARATOR          = 5'h16;
  localparam rvm_idx_t IDX_TWO_WIRE            = 5'h17;
  localparam rvm_idx_t IDX_SELF_PROGRAM_READY  = 5'h18;

  typedef enum logic [1:0] {
    ST_START,
    ST_IDLE,
    ST_OFFER
  } rvm_state_e;

  // vector handed to the fetch logic
  typedef struct packed {
    logic      valid;
    rvm_idx_t  idx;
    rvm_addr_t addr;
  } rvm_vec_s;

  // reset entry handed to the fetch logic
  typedef struct packed {
    logic      go;
    rvm_addr_t addr;
  } rvm_rst_s;

endpackage

/* File: verilog/rvm_vector_map.sv */
// reset and interrupt vector address generator
`timescale 1ns/1ps
module rvm_vector_map (
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_boot_reset_fuse,
  input  wire logic              i_vector_select_bit,
  input  wire rvm_pkg::rvm_addr_t i_boot_start,
  input  wire rvm_pkg::rvm_irq_t  i_irq_pending,
  input  wire logic              i_vec_taken,
  output rvm_pkg::rvm_rst_s       o_rst,
  output rvm_pkg::rvm_vec_s       o_vec,
  output logic                   o_fuse_programmed
);
  import rvm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // fuse strap, caught at the first edge after reset release

  logic        fuse_ff;
  logic        nxt_fuse;
  rvm_state_e  state_ff;
  rvm_state_e  nxt_state;
  rvm_rst_s    rst_ff;
  rvm_rst_s    nxt_rst;
  rvm_vec_s    vec_ff;
  rvm_vec_s    nxt_vec;

  always_comb begin
    nxt_fuse = fuse_ff;
    nxt_rst  = rst_ff;
    nxt_rst.go = 1'b0;
    if (state_ff == ST_START) begin
      nxt_fuse = i_boot_reset_fuse;
      nxt_rst.go = 1'b1;
      if (i_boot_reset_fuse == FUSE_PROGRAMMED) begin
        nxt_rst.addr = i_boot_start;
      end else begin
        nxt_rst.addr = APP_RESET_ADDR;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fuse_ff <= 1'b1;
      rst_ff  <= '0;
    end else begin
      fuse_ff <= nxt_fuse;
      rst_ff  <= nxt_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lowest pending vector number wins

  rvm_idx_t  win_idx;
  logic      win_any;
  rvm_addr_t table_base;

  always_comb begin
    win_idx = '0;
    win_any = 1'b0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (i_irq_pending[i]) begin
        win_idx = IDX_W'(i);
        win_any = 1'b1;
      end
    end
  end

  // table start moves with the select bit only, never with the fuse
  always_comb begin
    if (i_vector_select_bit) begin
      table_base = i_boot_start + APP_TABLE_BASE;
    end else begin
      table_base = APP_TABLE_BASE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // offer state machine

  always_comb begin
    nxt_state = state_ff;
    nxt_vec   = vec_ff;
    unique case (state_ff)
      ST_START: begin
        nxt_state = ST_IDLE;
      end
      ST_IDLE: begin
        if (win_any) begin
          nxt_vec.valid = 1'b1;
          nxt_vec.idx   = win_idx;
          nxt_vec.addr  = table_base + ADDR_W'(win_idx);
          nxt_state     = ST_OFFER;
        end
      end
      ST_OFFER: begin
        if (i_vec_taken) begin
          nxt_vec.valid = 1'b0;
          nxt_state     = ST_IDLE;
        end
      end
      default: begin
        nxt_vec.valid = 1'b0;
        nxt_state     = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= ST_START;
      vec_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      vec_ff   <= nxt_vec;
    end
  end

  assign o_rst             = rst_ff;
  assign o_vec             = vec_ff;
  assign o_fuse_programmed = (fuse_ff == FUSE_PROGRAMMED);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_lone_app(rvm_idx_t k);
    state_ff == ST_IDLE && !i_vector_select_bit && i_irq_pending == (IRQ_N'(1) << k);
  endsequence

  sequence s_offer(rvm_addr_t a);
    o_vec.valid && o_vec.addr == a;
  endsequence

  property p_reset_app;
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_ff == ST_START && i_boot_reset_fuse) |=> o_rst.go && o_rst.addr == 12'h000;
  endproperty
  a_reset_app: assert property (p_reset_app) else $error("reset word not zero");

  property p_ext;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_EXT_IRQ_1) |=> s_offer(12'h002);
  endproperty
  a_ext: assert property (p_ext) else $error("ext request 1 word wrong");

  property p_watchdog;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_WATCHDOG_TIMEOUT) |=> s_offer(12'h006);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog word wrong");

  property p_t2;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T2_OVERFLOW) |=> s_offer(12'h009);
  endproperty
  a_t2: assert property (p_t2) else $error("timer 2 overflow word wrong");

  property p_t1;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T1_CAPTURE) |=> s_offer(12'h00a);
  endproperty
  a_t1: assert property (p_t1) else $error("timer 1 capture word wrong");

  property p_t0;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T0_OVERFLOW) |=> s_offer(12'h010);
  endproperty
  a_t0: assert property (p_t0) else $error("timer 0 overflow word wrong");

  property p_spi;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_SERIAL_PERIPH_DONE) |=> s_offer(12'h011);
  endproperty
  a_spi: assert property (p_spi) else $error("serial done word wrong");

  property p_uart;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_UART_TX_DONE) |=> s_offer(12'h014);
  endproperty
  a_uart: assert property (p_uart) else $error("uart tx done word wrong");

  property p_last;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_SELF_PROGRAM_READY) |=> s_offer(12'h019);
  endproperty
  a_last: assert property (p_last) else $error("self program word wrong");

  property p_ext0;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_EXT_IRQ_0) |=> s_offer(12'h001);
  endproperty
  a_ext0: assert property (p_ext0) else $error("ext request 0 word wrong");

  property p_pin0;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_PIN_CHANGE_IRQ_0) |=> s_offer(12'h003);
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin change 0 word wrong");

  property p_pin1;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_PIN_CHANGE_IRQ_1) |=> s_offer(12'h004);
  endproperty
  a_pin1: assert property (p_pin1) else $error("pin change 1 word wrong");

  property p_pin2;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_PIN_CHANGE_IRQ_2) |=> s_offer(12'h005);
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin change 2 word wrong");

  property p_t2_a;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T2_MATCH_A) |=> s_offer(12'h007);
  endproperty
  a_t2_a: assert property (p_t2_a) else $error("timer 2 match a word wrong");

  property p_t2_b;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T2_MATCH_B) |=> s_offer(12'h008);
  endproperty
  a_t2_b: assert property (p_t2_b) else $error("timer 2 match b word wrong");

  property p_t1_a;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T1_MATCH_A) |=> s_offer(12'h00b);
  endproperty
  a_t1_a: assert property (p_t1_a) else $error("timer 1 match a word wrong");

  property p_t1_b;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T1_MATCH_B) |=> s_offer(12'h00c);
  endproperty
  a_t1_b: assert property (p_t1_b) else $error("timer 1 match b word wrong");

  property p_t1_ovf;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T1_OVERFLOW) |=> s_offer(12'h00d);
  endproperty
  a_t1_ovf: assert property (p_t1_ovf) else $error("timer 1 overflow word wrong");

  property p_t0_a;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T0_MATCH_A) |=> s_offer(12'h00e);
  endproperty
  a_t0_a: assert property (p_t0_a) else $error("timer 0 match a word wrong");

  property p_t0_b;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_T0_MATCH_B) |=> s_offer(12'h00f);
  endproperty
  a_t0_b: assert property (p_t0_b) else $error("timer 0 match b word wrong");

  property p_uart_rx;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_UART_RX_DONE) |=> s_offer(12'h012);
  endproperty
  a_uart_rx: assert property (p_uart_rx) else $error("uart rx done word wrong");

  property p_uart_empty;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_UART_TX_EMPTY) |=> s_offer(12'h013);
  endproperty
  a_uart_empty: assert property (p_uart_empty) else $error("uart empty word wrong");

  property p_conv;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_CONVERSION_DONE) |=> s_offer(12'h015);
  endproperty
  a_conv: assert property (p_conv) else $error("conversion word wrong");

  property p_nv;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_NV_READY) |=> s_offer(12'h016);
  endproperty
  a_nv: assert property (p_nv) else $error("nonvolatile ready word wrong");

  property p_comp;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_COMPARATOR) |=> s_offer(12'h017);
  endproperty
  a_comp: assert property (p_comp) else $error("comparator word wrong");

  property p_two_wire;
    @(posedge i_clk) disable iff (!i_arst_n)
    s_lone_app(IDX_TWO_WIRE) |=> s_offer(12'h018);
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two wire word wrong");

  property p_reset_boot;
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_ff == ST_START && !i_boot_reset_fuse) |=>
      o_rst.go && o_rst.addr == $past(i_boot_start) ##1 !o_rst.go;
  endproperty
  a_reset_boot: assert property (p_reset_boot) else $error("boot reset word wrong");

  property p_moved;
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_ff == ST_IDLE && i_vector_select_bit && i_irq_pending[IDX_EXT_IRQ_0]) |=>
      o_vec.valid && o_vec.idx == IDX_EXT_IRQ_0 && o_vec.addr == $past(i_boot_start) + 12'h001;
  endproperty
  a_moved: assert property (p_moved) else $error("moved table word wrong");

  property p_lowest;
    @(posedge i_clk) disable iff (!i_arst_n)
    (state_ff == ST_IDLE && i_irq_pending[IDX_T2_MATCH_A] && i_irq_pending[IDX_TWO_WIRE]) |=>
      o_vec.idx <= IDX_T2_MATCH_A;
  endproperty
  a_lowest: assert property (p_lowest) else $error("lower vector not first");

  property p_hold;
    @(posedge i_clk) disable iff (!i_arst_n)
    (o_vec.valid && !i_vec_taken) |=> o_vec.valid && $stable(o_vec.addr);
  endproperty
  a_hold: assert property (p_hold) else $error("offer dropped before taken");

endmodule

/* File: bench/rvm_core_model.sv */
// core fetch and request source model facing the vector map
`timescale 1ns/1ps
module rvm_core_model (
  input  wire logic              i_clk,
  input  wire logic              i_arst_n,
  input  wire rvm_pkg::rvm_vec_s i_vec,
  input  wire logic              i_load,
  input  wire rvm_pkg::rvm_irq_t i_mask,
  input  wire logic              i_slow,
  output rvm_pkg::rvm_irq_t      o_pending,
  output logic                   o_taken
);
  import rvm_pkg::*;
  logic [2:0] wait_ff;
  logic       ripe;
  assign ripe = (wait_ff == (i_slow ? 3'h3 : 3'h0));
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pending <= '0;
      o_taken   <= 1'b0;
      wait_ff   <= 3'h0;
    end else begin
      o_taken <= 1'b0;
      if (i_load) begin
        o_pending <= o_pending | i_mask;
      end
      // the source is dropped at the take edge, before the next pick
      if (i_vec.valid && o_taken) begin
        o_pending[i_vec.idx] <= 1'b0;
      end else if (i_vec.valid) begin
        o_taken <= ripe;
        wait_ff <= ripe ? 3'h0 : wait_ff + 3'h1;
      end
    end
  end
endmodule

/* File: bench/test_reset_irq_vector_map.sv */
// self-checking bench for the vector map
`timescale 1ns/1ps
module test_reset_irq_vector_map;
  import rvm_pkg::*;
  logic      i_clk;
  logic      i_arst_n;
  logic      fuse;
  logic      sel;
  rvm_addr_t boot;
  rvm_irq_t  pend;
  logic      taken;
  rvm_rst_s  rst;
  rvm_vec_s  vec;
  logic      fprog;
  logic      load;
  rvm_irq_t  mask;
  logic      slow;
  int        mismatches;
  int        n_compared;
  int        cycles;

  rvm_vector_map u_rvm_vector_map (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_boot_reset_fuse(fuse),
    .i_vector_select_bit(sel), .i_boot_start(boot), .i_irq_pending(pend),
    .i_vec_taken(taken), .o_rst(rst), .o_vec(vec), .o_fuse_programmed(fprog)
  );
  rvm_core_model u_rvm_core_model (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_vec(vec), .i_load(load),
    .i_mask(mask), .i_slow(slow), .o_pending(pend), .o_taken(taken)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic wrap_up;
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic chk_val(input string n, input rvm_addr_t e, input rvm_addr_t g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic load_mask(input rvm_irq_t m);
    load = 1'b1;
    mask = m;
    @(negedge i_clk);
    load = 1'b0;
  endtask

  task automatic expect_vec(input int k, input rvm_addr_t base);
    int n;
    n = 0;
    while (!(vec.valid === 1'b1 && taken === 1'b1) && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    chk_bit("vec taken", 1'b1, vec.valid & taken);
    chk_val("vec idx", 12'(k), {7'h00, vec.idx});
    chk_val("vec addr", base + 12'(k), vec.addr);
    @(negedge i_clk);
  endtask

  task automatic do_reset(input logic f, input rvm_addr_t b);
    i_arst_n = 1'b0;
    fuse = f;
    boot = b;
    repeat (16) @(negedge i_clk);
    chk_bit("go in reset", 1'b0, rst.go);
    chk_bit("fuse in reset", 1'b0, fprog);
    i_arst_n = 1'b1;
    @(negedge i_clk);
    chk_bit("reset go", 1'b1, rst.go);
    chk_val("reset addr", f ? 12'h000 : b, rst.addr);
    chk_bit("fuse programmed", ~f, fprog);
    fuse = ~f;
    @(negedge i_clk);
    chk_bit("go after pulse", 1'b0, rst.go);
    chk_val("reset addr held", f ? 12'h000 : b, rst.addr);
    chk_bit("fuse held", ~f, fprog);
  endtask

  task automatic run_table(input logic f, input logic s, input rvm_addr_t b, input logic w);
    sel = s;
    slow = w;
    do_reset(f, b);
    load_mask('1);
    for (int k = 0; k < 25; k++) begin
      expect_vec(k, s ? b + 12'h001 : 12'h001);
    end
  endtask

  task automatic late_arrival;
    int n;
    n = 0;
    load_mask(25'h1000000);
    while (vec.valid !== 1'b1 && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    load_mask(25'h0000001);
    expect_vec(24, boot + 12'h001);
    expect_vec(0, boot + 12'h001);
  endtask

  // nothing pending: vector words stay free for plain code
  task automatic quiet_table;
    repeat (8) begin
      @(negedge i_clk);
      chk_bit("offer while quiet", 1'b0, vec.valid);
    end
  endtask

  // each source alone, application table
  task automatic lone_sources;
    for (int k = 0; k < 25; k++) begin
      load_mask(rvm_irq_t'(1) << k);
      expect_vec(k, APP_TABLE_BASE);
    end
  endtask

  initial begin
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    i_arst_n = 1'b0;
    fuse = 1'b1;
    sel = 1'b0;
    boot = 12'hc00;
    load = 1'b0;
    mask = '0;
    slow = 1'b0;
    run_table(1'b1, 1'b0, 12'hc00, 1'b0);
    quiet_table();
    lone_sources();
    run_table(1'b1, 1'b1, 12'hc00, 1'b1);
    run_table(1'b0, 1'b0, 12'h800, 1'b1);
    run_table(1'b0, 1'b1, 12'h800, 1'b0);
    slow = 1'b1;
    late_arrival();
    wrap_up();
  end
endmodule
